// >>> logic/vis_pkg.sv
/*
 Package for the video input sync and field select block: register offsets,
 field positions, reset values, modes and carrier structs.
 Assumes a byte-wide register port and one 125 MHz core clock.
*/
package vis_pkg;
    // Register offsets
    localparam logic [7:0] VIS_OFF_FFW = 8'hC0;
    localparam logic [7:0] VIS_OFF_ARS = 8'hC1;
    localparam logic [7:0] VIS_OFF_SSP = 8'hC2;
    localparam logic [7:0] VIS_OFF_IFE = 8'hC3;
    // Reset values
    localparam logic [7:0] VIS_RST_FFW = 8'h14;
    localparam logic [7:0] VIS_RST_ARS = 8'h01;
    localparam logic [7:0] VIS_RST_SSP = 8'h04;
    localparam logic [7:0] VIS_RST_IFE = 8'h00;
    // Writable bit masks
    localparam logic [7:0] VIS_MSK_FFW = 8'hDE;
    localparam logic [7:0] VIS_MSK_ARS = 8'h3D;
    localparam logic [7:0] VIS_MSK_SSP = 8'h5E;
    localparam logic [7:0] VIS_MSK_IFE = 8'h03;
    // Field positions
    localparam int VIS_B_FRAME_SEL = 7;
    localparam int VIS_B_TEST_GEN = 6;
    localparam int VIS_B_FIELD_GEN = 4;
    localparam int VIS_B_FIELD_POL = 3;
    localparam int VIS_B_WIDTH_LO = 1;
    localparam int VIS_B_ACT_LO = 3;
    localparam int VIS_B_EMB_FIELD = 2;
    localparam int VIS_B_REGION = 0;
    localparam int VIS_B_SYNC_FIELD = 6;
    localparam int VIS_B_VS_SRC = 4;
    localparam int VIS_B_HS_SRC = 3;
    localparam int VIS_B_VS_POL = 2;
    localparam int VIS_B_HS_POL = 1;
    localparam int VIS_B_RGB565 = 1;
    localparam int VIS_B_EMB_SYNC = 0;
    // Width codes
    localparam logic [1:0] VIS_W8 = 2'h0;
    localparam logic [1:0] VIS_W16 = 2'h1;
    // Embedded code preamble bytes
    localparam logic [7:0] VIS_PRE_FF = 8'hFF;
    localparam logic [7:0] VIS_PRE_00 = 8'h00;
    localparam int VIS_BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        VIS_SCAN = 2'b00,
        VIS_P1 = 2'b01,
        VIS_P2 = 2'b11,
        VIS_XY = 2'b10
    } vis_code_e;

    typedef struct packed {
        logic hValid;
        logic vValid;
        logic dValid;
        logic hSync;
        logic vSync;
        logic field;
        logic [23:0] data;
    } vis_pins_s;

    typedef struct packed {
        logic [23:0] pixel;
        logic rgb565;
        logic [1:0] width;
        logic hSync;
        logic vSync;
        logic field;
        logic framePulse;
    } vis_word_s;
endpackage : vis_pkg

// >>> logic/vis_sync2.sv
/*
 Two flip-flop synchroniser, parameterised width.
 Assumes the input comes from outside the ref_clk domain.
*/
`timescale 1ns/10ps
module vis_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } vis_sy_s;
    vis_sy_s st_reg;
    vis_sy_s st_next;

    always_comb begin
        st_next.s1 = asyncIn;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign syncOut = st_reg.s2;
endmodule : vis_sync2

// >>> logic/vis_buf2.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock; output data come from registers.
*/
`timescale 1ns/10ps
module vis_buf2 (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire vis_pkg::vis_word_s inWord,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output vis_pkg::vis_word_s outWord
);
    typedef struct packed {
        vis_pkg::vis_word_s [1:0] mem;
        logic rdPtr;
        logic wrPtr;
        logic [1:0] count;
    } vis_bf_s;
    vis_bf_s st_reg;
    vis_bf_s st_next;
    logic push;
    logic pop;

    assign inReady = (st_reg.count != 2'h2);
    assign outValid = (st_reg.count != 2'h0);
    assign outWord = st_reg.mem[st_reg.rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wrPtr] = inWord;
            st_next.wrPtr = ~st_reg.wrPtr;
        end
        if (pop) begin
            st_next.rdPtr = ~st_reg.rdPtr;
        end
        st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : vis_buf2

// >>> logic/vis_video_input.sv
/*
 Video input configuration and selection: four control registers, sync,
 field and active-video selection, polarity, width and 5-6-5 tagging.
 Assumes pixel pins and the pixel clock are asynchronous to ref_clk and
 that the pixel clock is well below a quarter of ref_clk.
*/
`timescale 1ns/10ps
module vis_video_input (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Video pins
    input wire logic pixClk,
    input wire logic [23:0] pixData,
    input wire logic hValidPin,
    input wire logic vValidPin,
    input wire logic dValidPin,
    input wire logic ext_horizontal_sync_pin,
    input wire logic ext_vertical_sync_pin,
    input wire logic fieldPin,
    // Processed stream
    output logic outValid,
    input wire logic outReady,
    output vis_pkg::vis_word_s outWord,
    output logic activeVideo,
    output logic overflow
);
    typedef struct packed {
        logic [7:0] ffw;
        logic [7:0] ars;
        logic [7:0] ssp;
        logic [7:0] ife;
        logic [7:0] rdata;
        logic clkPrev;
        vis_pkg::vis_code_e code;
        logic embField;
        logic embV;
        logic embH;
        logic hPrev;
        logic vPrev;
        logic syncField;
        logic genField;
        logic active;
        logic ovf;
        vis_pkg::vis_word_s word;
        logic wordValid;
    } vis_st_s;
    vis_st_s st_reg;
    vis_st_s st_next;

    vis_pkg::vis_pins_s pinsAsync;
    vis_pkg::vis_pins_s pins;
    logic clkSync;
    logic bufReady;
    logic pixEdge;
    logic [1:0] width;
    logic [2:0] actSel;
    logic hRaw;
    logic vRaw;
    logic hSel;
    logic vSel;
    logic fieldSel;
    logic fieldOut;
    logic newFrame;
    logic actNext;
    logic [7:0] sample;

    assign pinsAsync = '{hValid: hValidPin, vValid: vValidPin, dValid: dValidPin,
                         hSync: ext_horizontal_sync_pin, vSync: ext_vertical_sync_pin,
                         field: fieldPin, data: pixData};

    vis_sync2 #(.W($bits(vis_pkg::vis_pins_s))) u_pinSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .asyncIn(pinsAsync),
        .syncOut(pins)
    );

    vis_sync2 #(.W(1)) u_clkSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .asyncIn(pixClk),
        .syncOut(clkSync)
    );

    vis_buf2 u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .inValid(st_reg.wordValid),
        .inReady(bufReady),
        .inWord(st_reg.word),
        .outValid(outValid),
        .outReady(outReady),
        .outWord(outWord)
    );

    // Rising edge of the sampled pixel clock is the pixel enable
    assign pixEdge = clkSync && !st_reg.clkPrev;
    assign width = st_reg.ffw[vis_pkg::VIS_B_WIDTH_LO +: 2];
    assign actSel = st_reg.ars[vis_pkg::VIS_B_ACT_LO +: 3];
    assign sample = pins.data[15:8];

    always_comb begin
        // Sync source choice, embedded codes override the pin/strobe picks
        if (st_reg.ife[vis_pkg::VIS_B_EMB_SYNC]) begin
            hRaw = st_reg.embH;
            vRaw = st_reg.embV;
        end else begin
            hRaw = st_reg.ssp[vis_pkg::VIS_B_HS_SRC] ? pins.hValid : pins.hSync;
            vRaw = st_reg.ssp[vis_pkg::VIS_B_VS_SRC] ? pins.vValid : pins.vSync;
        end
        hSel = hRaw ^ st_reg.ssp[vis_pkg::VIS_B_HS_POL];
        vSel = vRaw ^ st_reg.ssp[vis_pkg::VIS_B_VS_POL];
        newFrame = vSel && !st_reg.vPrev;
        if (st_reg.ars[vis_pkg::VIS_B_EMB_FIELD]) begin
            fieldSel = st_reg.embField;
        end else if (st_reg.ssp[vis_pkg::VIS_B_SYNC_FIELD]) begin
            fieldSel = st_reg.syncField;
        end else if (st_reg.ffw[vis_pkg::VIS_B_FIELD_GEN]) begin
            fieldSel = st_reg.genField;
        end else begin
            fieldSel = pins.field;
        end
        fieldOut = fieldSel ^ st_reg.ffw[vis_pkg::VIS_B_FIELD_POL];
        // Active video qualification
        if (actSel[0]) begin
            actNext = st_reg.embH;
        end else if (actSel[1]) begin
            actNext = pins.hValid;
        end else if (actSel[2]) begin
            actNext = pins.hValid && pins.dValid;
        end else if (st_reg.ars[vis_pkg::VIS_B_REGION]) begin
            actNext = pins.hValid && pins.dValid;
        end else begin
            actNext = pins.hValid && pins.vValid;
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.clkPrev = clkSync;
        st_next.wordValid = 1'b0;
        // Register writes keep only the defined bits
        if (regWrite) begin
            case (regAddr)
                vis_pkg::VIS_OFF_FFW: st_next.ffw = regWdata & vis_pkg::VIS_MSK_FFW;
                vis_pkg::VIS_OFF_ARS: st_next.ars = regWdata & vis_pkg::VIS_MSK_ARS;
                vis_pkg::VIS_OFF_SSP: st_next.ssp = regWdata & vis_pkg::VIS_MSK_SSP;
                vis_pkg::VIS_OFF_IFE: st_next.ife = regWdata & vis_pkg::VIS_MSK_IFE;
                default: st_next.ffw = st_reg.ffw;
            endcase
        end
        case (regAddr)
            vis_pkg::VIS_OFF_FFW: st_next.rdata = st_reg.ffw;
            vis_pkg::VIS_OFF_ARS: st_next.rdata = st_reg.ars;
            vis_pkg::VIS_OFF_SSP: st_next.rdata = st_reg.ssp;
            vis_pkg::VIS_OFF_IFE: st_next.rdata = st_reg.ife;
            default: st_next.rdata = 8'h00;
        endcase
        if (pixEdge) begin
            // Embedded code search: FF 00 00 then the flag byte
            case (st_reg.code)
                vis_pkg::VIS_SCAN: begin
                    if (sample == vis_pkg::VIS_PRE_FF) begin
                        st_next.code = vis_pkg::VIS_P1;
                    end
                end
                vis_pkg::VIS_P1: begin
                    st_next.code = (sample == vis_pkg::VIS_PRE_00) ? vis_pkg::VIS_P2
                                                                   : vis_pkg::VIS_SCAN;
                end
                vis_pkg::VIS_P2: begin
                    st_next.code = (sample == vis_pkg::VIS_PRE_00) ? vis_pkg::VIS_XY
                                                                   : vis_pkg::VIS_SCAN;
                end
                vis_pkg::VIS_XY: begin
                    // Bit 6 field, bit 5 vertical blank, bit 4 end of active video
                    st_next.embField = sample[6];
                    st_next.embV = sample[5];
                    st_next.embH = !sample[4];
                    st_next.code = vis_pkg::VIS_SCAN;
                end
                default: st_next.code = vis_pkg::VIS_SCAN;
            endcase
            st_next.hPrev = hSel;
            st_next.vPrev = vSel;
            // Odd field when vertical sync starts away from the line start
            if (newFrame) begin
                st_next.syncField = !(hSel && !st_reg.hPrev);
                st_next.genField = !st_reg.genField;
            end
            st_next.active = actNext;
            st_next.word.pixel = (width == vis_pkg::VIS_W8) ? {16'h0000, sample}
                               : (width == vis_pkg::VIS_W16) ? {8'h00, pins.data[15:0]}
                               : pins.data;
            st_next.word.width = width;
            st_next.word.rgb565 = st_reg.ife[vis_pkg::VIS_B_RGB565]
                                  && (width == vis_pkg::VIS_W16);
            st_next.word.hSync = hSel;
            st_next.word.vSync = vSel;
            st_next.word.field = fieldOut;
            st_next.word.framePulse = st_reg.ffw[vis_pkg::VIS_B_FRAME_SEL]
                                      ? newFrame : (fieldOut != st_reg.word.field);
            st_next.wordValid = actNext;
            // A full buffer drops the word; sticky flag reports it
            if (actNext && !bufReady) begin
                st_next.ovf = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.ffw <= vis_pkg::VIS_RST_FFW;
            st_reg.ars <= vis_pkg::VIS_RST_ARS;
            st_reg.ssp <= vis_pkg::VIS_RST_SSP;
            st_reg.ife <= vis_pkg::VIS_RST_IFE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign regRdata = st_reg.rdata;
    assign activeVideo = st_reg.active;
    assign overflow = st_reg.ovf;

    // Assertions
    unused_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_reg.ffw & ~vis_pkg::VIS_MSK_FFW) == 8'h00 && st_reg.ife[7:2] == 6'h00)
        else $error("Unused register bit set");
    width_map_a: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg.wordValid && st_reg.word.width == vis_pkg::VIS_W8 |-> st_reg.word.pixel[23:8] == 16'h0000)
        else $error("8-bit word carries high bits");
    rgb_tag_a: assert property (@(posedge ref_clk) disable iff (rst)
        st_reg.word.rgb565 |-> st_reg.word.width == vis_pkg::VIS_W16)
        else $error("5-6-5 tag outside 16-bit mode");
    hsync_pol_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && !st_reg.ife[0] && !st_reg.ssp[3] |=> st_reg.hPrev == ($past(pins.hSync) ^ $past(st_reg.ssp[1])))
        else $error("Horizontal sync source or polarity wrong");
    vsync_pol_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && !st_reg.ife[0] && st_reg.ssp[4] |=> st_reg.vPrev == ($past(pins.vValid) ^ $past(st_reg.ssp[2])))
        else $error("Vertical sync source or polarity wrong");
    emb_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && st_reg.ife[0] |=> st_reg.hPrev == ($past(st_reg.embH) ^ $past(st_reg.ssp[1])))
        else $error("Embedded sync not used");
    field_emb_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && st_reg.ars[2] |=> st_reg.word.field == ($past(st_reg.embField) ^ $past(st_reg.ffw[3])))
        else $error("Field not from embedded flag");
    region_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && actSel == 3'h0 && !st_reg.ars[0] |=> st_reg.active == ($past(pins.hValid) && $past(pins.vValid)))
        else $error("Region qualification wrong");
    field_pin_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && !st_reg.ars[2] && !st_reg.ssp[6] && !st_reg.ffw[4]
        |=> st_reg.word.field == ($past(pins.field) ^ $past(st_reg.ffw[3])))
        else $error("Field not from field pin");
    frame_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        pixEdge && st_reg.ffw[7] |=> st_reg.word.framePulse == ($past(vSel) && !$past(st_reg.vPrev)))
        else $error("Frame pulse not from vertical sync");
endmodule : vis_video_input

// >>> bench/vis_pix_source.sv
/*
 Pixel source model standing at the far side of the video input pins.
 Each call ends with its own gap after the word; the link clock idles low between words.
*/
`timescale 1ns/10ps
module vis_pix_source (
    // Link clock
    output logic pixClk,
    // Pixel pins
    output vis_pkg::vis_pins_s pins
);
    initial begin
        pixClk = 1'h0;
        pins = '0;
    end

    // One word per call, 125 ns link period; pins settle half a period before the rise
    task automatic sendPix(input vis_pkg::vis_pins_s p);
        pins = p;
        #62.5;
        pixClk = 1'h1;
        #62.5;
        pixClk = 1'h0;
        // Hold time is over, so stale data must not look valid; a gap keeps the next call apart
        #8;
        pins.data = ~p.data;
        #8;
    endtask : sendPix
endmodule : vis_pix_source

// >>> bench/testbench.sv
/*
 Self-checking bench for the video input block: register access, source and
 polarity selection, width, 5-6-5 tagging, active-video modes and buffer stall.
 Assumes the pixel source model and a free-running 125 MHz core clock.
*/
`timescale 1ns/10ps
module testbench;
    logic ref_clk;
    logic rst;
    logic regWrite;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic pixClk;
    vis_pkg::vis_pins_s pins;
    logic outValid;
    logic outReady;
    vis_pkg::vis_word_s outWord;
    logic activeVideo;
    logic overflow;
    int mismatches;
    int check_count;
    logic [7:0] cfg [4];
    logic [7:0] offs [4] = '{vis_pkg::VIS_OFF_FFW, vis_pkg::VIS_OFF_ARS,
        vis_pkg::VIS_OFF_SSP, vis_pkg::VIS_OFF_IFE};
    logic [7:0] rsts [4] = '{vis_pkg::VIS_RST_FFW, vis_pkg::VIS_RST_ARS,
        vis_pkg::VIS_RST_SSP, vis_pkg::VIS_RST_IFE};
    logic [7:0] msks [4] = '{vis_pkg::VIS_MSK_FFW, vis_pkg::VIS_MSK_ARS,
        vis_pkg::VIS_MSK_SSP, vis_pkg::VIS_MSK_IFE};
    // Config {C0,C1,C2,C3}; field generation stays off so the field pin is the source
    logic [31:0] cases [10] = '{32'h0001_0000, 32'h0201_0602, 32'h0C01_1802,
        32'h0600_0000, 32'h0600_0400, 32'h0210_0000, 32'h0220_0000,
        32'h0220_0000, 32'h0030_0000, 32'h0001_0000};
    // Pins {hValid,vValid,dValid,hSync,vSync,field}
    logic [5:0] ctls [10] = '{6'h2D, 6'h2A, 6'h39, 6'h2F, 6'h30, 6'h20, 6'h28,
        6'h36, 6'h24, 6'h30};

    always #4 ref_clk = ~ref_clk;

    vis_pix_source src (
        .pixClk(pixClk),
        .pins(pins)
    );

    vis_video_input dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .regWrite(regWrite),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regRdata(regRdata),
        .pixClk(pixClk),
        .pixData(pins.data),
        .hValidPin(pins.hValid),
        .vValidPin(pins.vValid),
        .dValidPin(pins.dValid),
        .ext_horizontal_sync_pin(pins.hSync),
        .ext_vertical_sync_pin(pins.vSync),
        .fieldPin(pins.field),
        .outValid(outValid),
        .outReady(outReady),
        .outWord(outWord),
        .activeVideo(activeVideo),
        .overflow(overflow)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'h1;
        @(negedge ref_clk);
        regWrite = 1'h0;
    endtask : regWr

    task automatic checkReg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        regAddr = a;
        @(negedge ref_clk);
        chk({24'h00_0000, regRdata}, {24'h00_0000, exp});
    endtask : checkReg

    function automatic logic isActive(input vis_pkg::vis_pins_s p);
        case (cfg[1][5:3])
            3'h2, 3'h6: return p.hValid;
            3'h0: return p.hValid & (cfg[1][0] ? p.dValid : p.vValid);
            3'h4: return p.hValid & p.dValid;
            default: return 1'h0;
        endcase
    endfunction : isActive

    function automatic vis_pkg::vis_word_s expWord(input vis_pkg::vis_pins_s p);
        vis_pkg::vis_word_s e;
        e.width = cfg[0][2:1];
        if (e.width == vis_pkg::VIS_W8) begin
            e.pixel = {16'h0000, p.data[15:8]};
        end else if (e.width == vis_pkg::VIS_W16) begin
            e.pixel = {8'h00, p.data[15:0]};
        end else begin
            e.pixel = p.data;
        end
        e.rgb565 = cfg[3][1] & (e.width == vis_pkg::VIS_W16);
        e.hSync = (cfg[2][3] ? p.hValid : p.hSync) ^ cfg[2][1];
        e.vSync = (cfg[2][4] ? p.vValid : p.vSync) ^ cfg[2][2];
        e.field = p.field ^ cfg[0][3];
        e.framePulse = 1'h0;
        return e;
    endfunction : expWord

    // Frame pulse timing is not modelled here, so bit 0 is left out of the compare
    task automatic popChk(input vis_pkg::vis_word_s e);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (outValid !== 1'h1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk({31'h0000_0000, outValid}, 32'h0000_0001);
        chk({2'h0, outWord[30:1]}, {2'h0, e[30:1]});
        outReady = 1'h1;
        @(negedge ref_clk);
        outReady = 1'h0;
    endtask : popChk

    // A marker word follows each probe, so a wrongly kept probe shows up first
    task automatic runCase(input logic [31:0] c, input logic [5:0] ctl, input logic [23:0] d);
        vis_pkg::vis_pins_s a;
        vis_pkg::vis_pins_s b;
        logic act;
        for (int k = 0; k < 4; k++) begin
            cfg[k] = c[31 - 8 * k -: 8];
            regWr(offs[k], cfg[k]);
        end
        a = {ctl, d};
        b = {6'h3A, ~d};
        act = isActive(a);
        src.sendPix(a);
        chk({31'h0000_0000, activeVideo}, {31'h0000_0000, act});
        src.sendPix(b);
        if (act) begin
            popChk(expWord(a));
        end
        popChk(expWord(b));
    endtask : runCase

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    initial begin
        #400000;
        mismatches++;
        summarize();
    end

    initial begin
        ref_clk = 1'h0;
        rst = 1'h1;
        regWrite = 1'h0;
        regAddr = vis_pkg::VIS_OFF_FFW;
        regWdata = 8'h00;
        outReady = 1'h0;
        mismatches = 0;
        check_count = 0;
        repeat (10) @(negedge ref_clk);
        rst = 1'h0;
        for (int i = 0; i < 4; i++) begin
            checkReg(offs[i], rsts[i]);
        end
        chk({31'h0000_0000, overflow}, 32'h0000_0000);
        // Test generation bit stays clear in every write
        for (int i = 0; i < 4; i++) begin
            regWr(offs[i], 8'hBF);
            checkReg(offs[i], 8'hBF & msks[i]);
        end
        regWr(8'hC4, 8'hFF);
        checkReg(8'hC4, 8'h00);
        // Field generation bit is written 0 in every case
        for (int i = 0; i < 10; i++) begin
            runCase(cases[i], ctls[i], 24'h5A_C3E1 + 24'(i));
        end
        // Receiver stalls: two words held, the third is refused
        for (int j = 0; j < 3; j++) begin
            src.sendPix({6'h28, 24'h12_3400 + 24'(j)});
        end
        @(negedge ref_clk);
        chk({31'h0000_0000, overflow}, 32'h0000_0001);
        popChk(expWord({6'h28, 24'h12_3400}));
        popChk(expWord({6'h28, 24'h12_3401}));
        @(negedge ref_clk);
        chk({31'h0000_0000, outValid}, 32'h0000_0000);
        summarize();
    end
endmodule : testbench
